/* File: design/srsl_defs.vh */
/*
 Snoop response state logic constants: snoop codes, line states, response bits.
 Assumes inclusion by the single design module; definitions only.
*/
`ifndef SRSL_DEFS_VH
`define SRSL_DEFS_VH
// Snoop codes on the snoop address channel.
`define SRSL_SNP_READONCE 4'h0
`define SRSL_SNP_READCLEAN 4'h2
`define SRSL_SNP_READNSD 4'h3
`define SRSL_SNP_READSHARED 4'h1
`define SRSL_SNP_READUNIQUE 4'h7
`define SRSL_SNP_CLEANINV 4'h9
`define SRSL_SNP_CLEANSHARED 4'h8
`define SRSL_SNP_MAKEINV 4'hd
// Line states: bit0 valid, bit1 dirty, bit2 unique.
`define SRSL_ST_I 3'h0
`define SRSL_ST_SC 3'h1
`define SRSL_ST_SD 3'h3
`define SRSL_ST_UC 3'h5
`define SRSL_ST_UD 3'h7
`define SRSL_ST_VALID 0
`define SRSL_ST_DIRTY 1
`define SRSL_ST_UNIQUE 2
// Response bit positions.
`define SRSL_RESP_DATA 0
`define SRSL_RESP_ERR 1
`define SRSL_RESP_PASSDIRTY 2
`define SRSL_RESP_ISSHARED 3
`define SRSL_RESP_WASUNIQUE 4
// Local pending write or evict kinds.
`define SRSL_WR_NONE 2'h0
`define SRSL_WR_CLEAN 2'h1
`define SRSL_WR_BACK 2'h2
`define SRSL_WR_EVICT 2'h3
`endif

/* File: design/srsl_snoop_resp.v */
/*
 Snoop response logic for one cache line slot of a cached master.
 Takes a snoop on the address channel, picks a legal end state, answers on
 the response channel, then sends the line on the data channel if needed.
 Assumes the line store supplies the current state and data by index, and
 takes the end-state update strobe.  One clock, synchronous reset.
*/
//
// Summary of operation
// [RULE1] Dirty line gives data except on invalidate-only.
// [RULE2] Read shared snoops end Shared or Invalid.
// [RULE3] Invalidating snoops leave no copy.
// [RULE4] Clean-shared snoop ends Clean or Invalid.
// [RULE5] Dirty stays dirty only without PassDirty.
// [RULE6] No upgrade in validity, dirtiness or uniqueness.
// [RULE7] Never UniqueDirty to UniqueClean.
// [RULE8] Write-back only with held responsibility.
// [RULE9] Pending write or evict applies first.
// [RULE10] ReadOnce keeps; read-shared picks shared ends.
// [RULE11] Clean-shared ends I, SC or kept UC.
// [RULE12] IsShared high exactly when line stays valid.
// [RULE13] Dirty to clean asserts PassDirty.
// [RULE14] Dirty to Invalid asserts PassDirty normally.
// [RULE15] Invalidate-only may drop PassDirty freely.
// [RULE16] Response bits follow the state change.
// [RULE17] Address, then response, then optional data.
// [RULE18] DataTransfer bit announces data phase.
// [RULE19] No response before address handshake.
// [RULE20] Dirty data made available except on invalidate-only.
// [RULE21] WasUnique only from a unique start.
// [RULE22] State updates when response accepted.
`timescale 1ns/100ps
`include "srsl_defs.vh"
module srsl_snoop_resp #(
	parameter ADDR_W = 32,
	parameter DATA_W = 32,
	parameter BEATS = 4,
	parameter BEAT_W = 2
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Snoop address channel
	input wire acValid,
	output wire acReady,
	input wire [ADDR_W-1:0] acAddr,
	input wire [3:0] acSnoop,
	// Snoop response channel
	output reg crValid,
	input wire crReady,
	output reg [4:0] crResp,
	// Snoop data channel
	output reg cdValid,
	input wire cdReady,
	output reg [DATA_W-1:0] cdData,
	output reg cdLast,
	// Line store side
	output reg [ADDR_W-1:0] lineAddr,
	input wire [2:0] lineState,
	input wire [1:0] pendWrite,
	output reg [BEAT_W-1:0] lineBeat,
	input wire [DATA_W-1:0] lineData,
	output reg stateWe,
	output reg [2:0] stateNew
);
	localparam S_IDLE = 2'h0;
	localparam S_RESP = 2'h1;
	localparam S_DATA = 2'h2;
	localparam S_EVAL = 2'h3;
	reg [1:0] state;
	reg [2:0] endState;
	reg [3:0] snoop;
	reg [2:0] startState;
	reg [2:0] next_end;
	reg [4:0] next_resp;
	reg [BEAT_W-1:0] beat;

	// Pending write-clean cleans the line; write-back or evict drops it.
	function [2:0] srsl_apply_write;
		input [2:0] st;
		input [1:0] wr;
		begin
			if (wr == `SRSL_WR_EVICT)
				srsl_apply_write = `SRSL_ST_I;
			else if (wr == `SRSL_WR_BACK)
				srsl_apply_write = `SRSL_ST_I;
			else if (wr == `SRSL_WR_CLEAN && st[`SRSL_ST_VALID])
				srsl_apply_write = st & 3'h5;
			else
				srsl_apply_write = st;
		end
	endfunction

	// Only one snoop is in flight, so the address is taken only when idle.
	assign acReady = (state == S_IDLE);

	always @* begin
		next_end = `SRSL_ST_I;
		next_resp = 5'h00;
		case (snoop)
		// [RULE10] ReadOnce keeps state
		`SRSL_SNP_READONCE: begin
			next_end = startState;
		end
		// [RULE2] read-shared end states
		`SRSL_SNP_READCLEAN, `SRSL_SNP_READNSD, `SRSL_SNP_READSHARED: begin
			// [RULE10] SD only from dirty
			next_end = startState & 3'h3;
		end
		// [RULE11] clean-shared ends clean
		`SRSL_SNP_CLEANSHARED: begin
			// [RULE4] drop the dirty bit
			if (startState == `SRSL_ST_UC)
				next_end = `SRSL_ST_UC;
			else if (startState[`SRSL_ST_VALID])
				next_end = `SRSL_ST_SC;
			else
				next_end = `SRSL_ST_I;
		end
		// [RULE3] invalidating snoops and unknown codes
		default: begin
			next_end = `SRSL_ST_I;
		end
		endcase
		// [RULE6] no upgrade by construction
		// [RULE7] UD never becomes UC
		// [RULE12] IsShared when valid
		next_resp[`SRSL_RESP_ISSHARED] = next_end[`SRSL_ST_VALID];
		// [RULE13] dirty to clean passes
		// [RULE14] dirty to invalid passes
		// [RULE15] MakeInvalid discards dirty
		// [RULE5] kept dirty needs no pass
		// [RULE16] response matches change
		next_resp[`SRSL_RESP_PASSDIRTY] = startState[`SRSL_ST_DIRTY] &&
			!next_end[`SRSL_ST_DIRTY] && snoop != `SRSL_SNP_MAKEINV;
		// [RULE1] data when dirty
		// [RULE20] dirty data available
		// [RULE18] DataTransfer announces data
		next_resp[`SRSL_RESP_DATA] = startState[`SRSL_ST_VALID] &&
			snoop != `SRSL_SNP_MAKEINV &&
			(startState[`SRSL_ST_DIRTY] || snoop == `SRSL_SNP_READONCE ||
			snoop == `SRSL_SNP_READCLEAN || snoop == `SRSL_SNP_READNSD ||
			snoop == `SRSL_SNP_READSHARED || snoop == `SRSL_SNP_READUNIQUE);
		// [RULE21] WasUnique from unique
		next_resp[`SRSL_RESP_WASUNIQUE] = startState[`SRSL_ST_UNIQUE];
	end

	always @(posedge clk) begin
		if (reset) begin
			state <= S_IDLE;
			snoop <= 4'h0;
			startState <= 3'h0;
			endState <= 3'h0;
			lineAddr <= {ADDR_W{1'b0}};
			crValid <= 1'b0;
			crResp <= 5'h00;
			cdValid <= 1'b0;
			cdData <= {DATA_W{1'b0}};
			cdLast <= 1'b0;
			beat <= {BEAT_W{1'b0}};
			lineBeat <= {BEAT_W{1'b0}};
			stateWe <= 1'b0;
			stateNew <= 3'h0;
		end else begin
			stateWe <= 1'b0;
			case (state)
			S_IDLE: begin
				// [RULE19] wait for address handshake
				if (acValid) begin
					lineAddr <= acAddr;
					snoop <= acSnoop;
					state <= S_EVAL;
				end
			end
			S_EVAL: begin
				// [RULE9] pending write applied first
				// [RULE8] cleaned line loses write-back right
				startState <= srsl_apply_write(lineState, pendWrite);
				state <= S_RESP;
			end
			S_RESP: begin
				// The response word is loaded with valid, so it never shows
				// a stale value while the interconnect may accept it.
				if (!crValid) begin
					crValid <= 1'b1;
					crResp <= next_resp;
					endState <= next_end;
				end
				// [RULE17] response before data
				if (crValid && crReady) begin
					crValid <= 1'b0;
					// [RULE22] update on acceptance
					stateWe <= 1'b1;
					stateNew <= next_end;
					beat <= {BEAT_W{1'b0}};
					lineBeat <= {BEAT_W{1'b0}};
					state <= next_resp[`SRSL_RESP_DATA] ? S_DATA : S_IDLE;
				end
			end
			S_DATA: begin
				if (!cdValid || cdReady) begin
					if (cdValid && cdLast) begin
						cdValid <= 1'b0;
						cdLast <= 1'b0;
						state <= S_IDLE;
					end else begin
						cdValid <= 1'b1;
						cdData <= lineData;
						cdLast <= (beat == BEATS - 1);
						beat <= beat + 1'b1;
						lineBeat <= beat + 1'b1;
					end
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end
endmodule

/* File: tb/srsl_chk_properties.sv */
/* Checker bound to the snoop response block.
 Assumes lineState holds steady from address to response. */
`timescale 1ns/100ps
module srsl_chk (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Snoop channels
	input wire acValid,
	input wire acReady,
	input wire [3:0] acSnoop,
	input wire crValid,
	input wire crReady,
	input wire [4:0] crResp,
	input wire cdValid,
	// Line store
	input wire [2:0] lineState,
	input wire [1:0] pendWrite,
	input wire stateWe,
	input wire [2:0] stateNew
);
	reg [3:0] snp = 4'h0;
	reg [2:0] st = 3'h0;
	reg [4:0] rsp = 5'h0;
	wire gives = st[1] && snp != 4'hd && pendWrite == 2'h0;
	always @(posedge clk) begin
		if (acValid && acReady) begin
			snp <= acSnoop;
			st <= lineState;
		end
		if (crValid && crReady)
			rsp <= crResp;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_take; acValid && acReady; endsequence
	sequence s_acc; crValid && crReady; endsequence
	property p_ans; s_take |-> ##1 !crValid ##[1:3] crValid; endproperty
	a_ans: assert property (p_ans) else $error("late response");
	property p_busy; crValid || cdValid |-> !acReady; endproperty
	a_busy: assert property (p_busy) else $error("ready busy");
	property p_upd; s_acc |-> ##1 stateWe; endproperty
	a_upd: assert property (p_upd) else $error("no update");
	property p_noup; stateWe |-> (stateNew & ~st) == 3'h0; endproperty
	a_noup: assert property (p_noup) else $error("upgrade");
	property p_inv; stateWe && snp inside {7, 9, 13} |-> !stateNew; endproperty
	a_inv: assert property (p_inv) else $error("copy kept");
	property p_shr; stateWe && snp inside {1, 2, 3} |-> !stateNew[2]; endproperty
	a_shr: assert property (p_shr) else $error("still unique");
	property p_iss; stateWe |-> rsp[3] == stateNew[0]; endproperty
	a_iss: assert property (p_iss) else $error("shared bit");
	property p_pd; stateWe && gives && !stateNew[1] |-> rsp[2]; endproperty
	a_pd: assert property (p_pd) else $error("pass dirty");
	property p_dat; stateWe && gives |-> rsp[0]; endproperty
	a_dat: assert property (p_dat) else $error("dirty data");
	property p_cd; cdValid |-> rsp[0]; endproperty
	a_cd: assert property (p_cd) else $error("data unannounced");
endmodule
bind srsl_snoop_resp srsl_chk u_chk (.*);

/* File: tb/srsl_icn.sv */
/* Interconnect model: issues snoops, takes responses and data.
 Assumes the caller starts just after a rising edge. */
`timescale 1ns/100ps
module srsl_icn (
	// Clock
	input wire clk,
	// Snoop channels
	output reg acValid = 1'b0,
	input wire acReady,
	output reg [31:0] acAddr = 32'h0,
	output reg [3:0] acSnoop = 4'h0,
	input wire crValid,
	output reg crReady = 1'b0,
	input wire [4:0] crResp,
	input wire cdValid,
	input wire [31:0] cdData,
	output reg cdReady = 1'b0
);
	reg [31:0] lastData = 32'h0;
	reg crOld = 1'b0;
	reg [4:0] resp = 5'h0;
	reg tmo = 1'b0;
	integer beats = 0;
	always @(posedge clk) begin
		crReady <= #1 crValid && crOld;
		crOld <= crValid && !crReady;
		cdReady <= #1 cdValid && !cdReady;
		if (cdValid && cdReady) begin
			beats <= beats + 1;
			lastData <= cdData;
		end
	end
	task snoop(input [3:0] c);
		integer n;
		begin
			beats = 0;
			n = 0;
			acSnoop = c;
			acAddr = 32'h40;
			acValid = 1'b1;
			do @(posedge clk); while (!acReady && ++n < 20);
			#1 acValid = 1'b0;
			acSnoop = ~c;
			acAddr = ~acAddr;
			do @(posedge clk); while (!(crValid && crReady) && ++n < 40);
			resp = crResp;
			if (resp[0])
				do @(posedge clk); while (!(cdValid && cdReady && cdLastOk()) && ++n < 80);
			tmo = n >= 40;
			#1;
		end
	endtask
	function cdLastOk;
		cdLastOk = tb_top.cdLast;
	endfunction
endmodule

/* File: tb/tb_top.sv */
/* Bench for the snoop response block.
 Assumes the interconnect model and the bound checker. */
`timescale 1ns/100ps
module tb_top;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg [2:0] lineState = 3'h0;
	reg [1:0] pendWrite = 2'h0;
	wire acValid, acReady, crValid, crReady, cdValid, cdReady, cdLast, stateWe;
	wire [31:0] acAddr, cdData, lineAddr;
	wire [3:0] acSnoop;
	wire [4:0] crResp;
	wire [1:0] lineBeat;
	wire [2:0] stateNew;
	wire [31:0] lineData = {16{lineBeat}};
	integer errors = 0;
	integer cmp_count = 0;
	integer i;
	reg [14:0] row [0:7];
	srsl_snoop_resp u_dut (.*);
	srsl_icn u_icn (.*);
	always #50 clk = ~clk;
	always @(posedge clk) if (stateWe) lineState <= #1 stateNew;
	task check(input [31:0] seen, input [31:0] exp, input [8*6:1] what);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("unexpected %0s: expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task test_done;
		begin
			$display("%0d compares, %0d mismatches", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task run(input [3:0] c, input [2:0] s, input [1:0] w);
		begin
			lineState = s;
			pendWrite = w;
			u_icn.snoop(c);
			if (u_icn.tmo) begin
				errors = errors + 1;
				test_done;
			end
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	initial begin
		row[0] = {4'h0, 3'h7, 3'h7, 5'h19};
		row[1] = {4'h1, 3'h7, 3'h3, 5'h19};
		row[2] = {4'h2, 3'h5, 3'h1, 5'h19};
		row[3] = {4'h3, 3'h3, 3'h3, 5'h09};
		row[4] = {4'h7, 3'h1, 3'h0, 5'h01};
		row[5] = {4'h9, 3'h7, 3'h0, 5'h15};
		row[6] = {4'hd, 3'h3, 3'h0, 5'h00};
		row[7] = {4'h8, 3'h3, 3'h1, 5'h0d};
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			run(row[i][14:11], row[i][10:8], 2'h0);
			check(lineState, row[i][7:5], "end");
			check(u_icn.resp, row[i][4:0], "resp");
			check(u_icn.beats, row[i][0] ? 4 : 0, "beats");
			if (row[i][0])
				check(u_icn.lastData, 32'hffffffff, "data");
			$display("row %0d done", i);
		end
		run(4'h1, 3'h7, 2'h2);
		check(u_icn.resp[3:0], 4'h0, "wbrsp");
		check(lineState, 3'h0, "wbend");
		run(4'h8, 3'h7, 2'h1);
		check(lineState, 3'h5, "wcend");
		$display("pending write test done");
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		run(4'h9, 3'h3, 2'h0);
		check(u_icn.resp, 5'h05, "rsresp");
		$display("reset test done");
		test_done;
	end
endmodule
